// *** rtl/jdep_top.sv ***
// Test access port with debug entry, protected state and boundary scan
`timescale 1ns/1ps
module jdep_top
  import jdep_pkg::*;
#(
  parameter int BSC_N = 8,
  parameter logic [31:0] ID_CODE = 32'h0a5a_5001
) (
  input wire logic clk,
  input wire logic nrst,
  input wire jdep_pins_t tapPins,
  input wire logic extRstN,
  input wire logic protStrap,
  input wire logic eraseDone,
  input wire jdep_map_req_t mapIn,
  input wire logic svcReq,
  input wire jdep_svc_t svcKind,
  input wire logic [BSC_N-1:0] coreOut,
  input wire logic [BSC_N-1:0] coreOeN,
  input wire logic [BSC_N-1:0] padIn,
  output logic tdo,
  output logic tdoOeN,
  output logic [BSC_N-1:0] padOut,
  output logic [BSC_N-1:0] padOeN,
  output logic coreHoldReset,
  output logic pinsEnabled,
  output logic protectedState,
  output logic debugUnitsEn,
  output logic mapGrant,
  output logic mapDeny,
  output logic svcGrant,
  output logic svcDeny
);
  // ID_CODE default is an arbitrary neutral value
  jdep_state_t s_reg;
  jdep_state_t s_next;
  jdep_pins_t pinS;
  logic rstPinS;
  logic [BSC_N-1:0] padInS;
  logic rise;
  logic fall;
  logic extest;
  logic tapOn;

  // Pin inputs pass two flip-flops before any logic
  jdep_sync #(.W(4)) syncCtl (
    .clk(clk),
    .nrst(nrst),
    .din({tapPins, extRstN}),
    .dout({pinS, rstPinS})
  );
  jdep_sync #(.W(BSC_N)) syncPad (
    .clk(clk),
    .nrst(nrst),
    .din(padIn),
    .dout(padInS)
  );

  // TCK edges seen by the block clock
  assign rise = pinS.tck & ~s_reg.tckPrev;
  assign fall = ~pinS.tck & s_reg.tckPrev;
  assign tapOn = (s_reg.ent == JDEP_ENT_ENABLED);
  assign extest = tapOn && (s_reg.ir == `JDEP_IR_EXTEST);

  // Standard sixteen-state controller
  function automatic jdep_tap_t tapNext(input jdep_tap_t st, input logic tms);
    case (st)
      JDEP_TLR: tapNext = tms ? JDEP_TLR : JDEP_RTI;
      JDEP_RTI: tapNext = tms ? JDEP_SEL_DR : JDEP_RTI;
      JDEP_SEL_DR: tapNext = tms ? JDEP_SEL_IR : JDEP_CAP_DR;
      JDEP_CAP_DR: tapNext = tms ? JDEP_EXIT1_DR : JDEP_SHIFT_DR;
      JDEP_SHIFT_DR: tapNext = tms ? JDEP_EXIT1_DR : JDEP_SHIFT_DR;
      JDEP_EXIT1_DR: tapNext = tms ? JDEP_UPD_DR : JDEP_PAUSE_DR;
      JDEP_PAUSE_DR: tapNext = tms ? JDEP_EXIT2_DR : JDEP_PAUSE_DR;
      JDEP_EXIT2_DR: tapNext = tms ? JDEP_UPD_DR : JDEP_SHIFT_DR;
      JDEP_UPD_DR: tapNext = tms ? JDEP_SEL_DR : JDEP_RTI;
      JDEP_SEL_IR: tapNext = tms ? JDEP_TLR : JDEP_CAP_IR;
      JDEP_CAP_IR: tapNext = tms ? JDEP_EXIT1_IR : JDEP_SHIFT_IR;
      JDEP_SHIFT_IR: tapNext = tms ? JDEP_EXIT1_IR : JDEP_SHIFT_IR;
      JDEP_EXIT1_IR: tapNext = tms ? JDEP_UPD_IR : JDEP_PAUSE_IR;
      JDEP_PAUSE_IR: tapNext = tms ? JDEP_EXIT2_IR : JDEP_PAUSE_IR;
      JDEP_EXIT2_IR: tapNext = tms ? JDEP_UPD_IR : JDEP_SHIFT_IR;
      JDEP_UPD_IR: tapNext = tms ? JDEP_SEL_DR : JDEP_RTI;
      default: tapNext = JDEP_TLR;
    endcase
  endfunction

  // Scan length selected by the instruction
  function automatic int drLen(input logic [`JDEP_IR_W-1:0] ir);
    case (ir)
      `JDEP_IR_IDCODE: drLen = `JDEP_DR_W;
      `JDEP_IR_SAMPLE, `JDEP_IR_EXTEST: drLen = BSC_N;
      default: drLen = 1;
    endcase
  endfunction

  // Manager port services allowed in the present protection state
  function automatic logic svcAllowed(input jdep_svc_t k, input logic prot);
    case (k)
      JDEP_SVC_CRC_RANGE: svcAllowed = ~prot;
      JDEP_SVC_HOLD_CLEAR: svcAllowed = ~prot;
      default: svcAllowed = 1'b1;
    endcase
  endfunction

  // Next state of the whole block
  always_comb begin
    logic ok;
    int len;
    ok = 1'b0;
    len = drLen(s_reg.ir);
    s_next = s_reg;
    s_next.tckPrev = pinS.tck;
    s_next.mapGrant = 1'b0;
    s_next.mapDeny = 1'b0;
    s_next.svcGrant = 1'b0;
    s_next.svcDeny = 1'b0;

    // Debug entry decided by TCK at reset pin release
    case (s_reg.ent)
      JDEP_ENT_RESET: begin
        if (rstPinS) begin
          s_next.prot = protStrap;
          if (pinS.tck) begin
            s_next.ent = JDEP_ENT_DISABLED;
          end else begin
            s_next.ent = JDEP_ENT_ARMED;
            s_next.hold = 1'b1;
          end
        end
      end
      JDEP_ENT_ARMED: begin
        if (fall) begin
          s_next.ent = JDEP_ENT_ENABLED;
        end
      end
      JDEP_ENT_ENABLED, JDEP_ENT_DISABLED: begin
      end
      default: s_next.ent = JDEP_ENT_RESET;
    endcase
    if (!rstPinS) begin
      s_next.ent = JDEP_ENT_RESET;
      s_next.hold = 1'b0;
    end

    // A finished erase lifts protection, as does a reset pin release with protStrap low
    if (eraseDone) begin
      s_next.prot = 1'b0;
    end
    s_next.dbgEn = ~s_next.prot;

    // Manager port services
    if (svcReq) begin
      ok = svcAllowed(svcKind, s_reg.prot);
      s_next.svcGrant = ok;
      s_next.svcDeny = ~ok;
      if (ok && svcKind == JDEP_SVC_HOLD_CLEAR) begin
        s_next.hold = 1'b0;
      end
    end

    // Memory access port gate
    if (mapIn.req) begin
      ok = rstPinS && !s_reg.prot && !(mapIn.write && mapIn.flashBuf && s_reg.hold);
      s_next.mapGrant = ok;
      s_next.mapDeny = ~ok;
    end

    // TAP stepped on TCK edges only, held in Test-Logic-Reset while the pins are off
    if (!tapOn) begin
      s_next.tap = JDEP_TLR;
      s_next.ir = `JDEP_IR_IDCODE;
      s_next.tdoOeN = 1'b1;
    end else begin
      if (s_reg.tap == JDEP_TLR) begin
        s_next.ir = `JDEP_IR_IDCODE;
      end
      if (rise) begin
        case (s_reg.tap)
          JDEP_CAP_IR: s_next.irShift = `JDEP_IR_CAPTURE;
          JDEP_SHIFT_IR: s_next.irShift = {pinS.tdi, s_reg.irShift[`JDEP_IR_W-1:1]};
          JDEP_UPD_IR: s_next.ir = s_reg.irShift;
          JDEP_CAP_DR: begin
            s_next.dr = '0;
            if (s_reg.ir == `JDEP_IR_IDCODE) begin
              s_next.dr = ID_CODE;
            end else if (len == BSC_N) begin
              s_next.dr[BSC_N-1:0] = padInS;
            end
          end
          JDEP_SHIFT_DR: begin
            for (int i = 0; i < `JDEP_DR_W; i++) begin
              if (i == len - 1) begin
                s_next.dr[i] = pinS.tdi;
              end else if (i < len - 1) begin
                s_next.dr[i] = s_reg.dr[i + 1];
              end
            end
          end
          JDEP_UPD_DR: begin
            if (len == BSC_N && s_reg.ir != `JDEP_IR_BYPASS) begin
              s_next.bsUpd = s_reg.dr;
            end
          end
          default: begin
          end
        endcase
        s_next.tap = tapNext(s_reg.tap, pinS.tms);
      end
      if (fall) begin
        s_next.tdo = (s_reg.tap == JDEP_SHIFT_IR) ? s_reg.irShift[0] : s_reg.dr[0];
        s_next.tdoOeN = !(s_reg.tap == JDEP_SHIFT_IR || s_reg.tap == JDEP_SHIFT_DR);
      end
    end

    // Pad drivers: core or boundary latches, floating in reset
    s_next.padOut = '0;
    s_next.padOut[BSC_N-1:0] = extest ? s_reg.bsUpd[BSC_N-1:0] : coreOut;
    s_next.padOeN = '1;
    if (rstPinS) begin
      s_next.padOeN[BSC_N-1:0] = extest ? '0 : coreOeN;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '{tap: JDEP_TLR, ent: JDEP_ENT_RESET, tckPrev: 1'b0, irShift: `JDEP_IR_CAPTURE,
                 ir: `JDEP_IR_IDCODE, dr: '0, bsUpd: '0, padOut: '0, padOeN: '1, tdo: 1'b0,
                 tdoOeN: 1'b1, hold: 1'b0, prot: 1'b0, dbgEn: 1'b1, mapGrant: 1'b0,
                 mapDeny: 1'b0, svcGrant: 1'b0, svcDeny: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register; pinsEnabled is decoded from its entry state
  assign tdo = s_reg.tdo;
  assign tdoOeN = s_reg.tdoOeN;
  assign padOut = s_reg.padOut[BSC_N-1:0];
  assign padOeN = s_reg.padOeN[BSC_N-1:0];
  assign coreHoldReset = s_reg.hold;
  assign pinsEnabled = tapOn;
  assign protectedState = s_reg.prot;
  assign debugUnitsEn = s_reg.dbgEn;
  assign mapGrant = s_reg.mapGrant;
  assign mapDeny = s_reg.mapDeny;
  assign svcGrant = s_reg.svcGrant;
  assign svcDeny = s_reg.svcDeny;

  // Counts TCK rises with TMS high, for the reset check
  logic [2:0] tmsHighCnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmsHighCnt <= '0;
    end else if (!tapOn) begin
      tmsHighCnt <= '0;
    end else if (rise) begin
      tmsHighCnt <= !pinS.tms ? 3'h0 : (tmsHighCnt == `JDEP_TMS_RESET_CNT) ? tmsHighCnt : tmsHighCnt + 3'h1;
    end
  end

  // Release of the reset pin with TCK low or high
  sequence relLow;
    s_reg.ent == JDEP_ENT_RESET && rstPinS && !pinS.tck;
  endsequence
  sequence relHigh;
    s_reg.ent == JDEP_ENT_RESET && rstPinS && pinS.tck;
  endsequence

  a_map_prot_deny: assert property (@(posedge clk) disable iff (!nrst)
    mapIn.req && s_reg.prot |=> mapDeny && !mapGrant) else $error("access granted while protected");
  a_hold_prot_keep: assert property (@(posedge clk) disable iff (!nrst)
    svcReq && svcKind == JDEP_SVC_HOLD_CLEAR && s_reg.prot && s_reg.hold && rstPinS |=> coreHoldReset && svcDeny)
    else $error("hold cleared while protected");
  a_crc_range_deny: assert property (@(posedge clk) disable iff (!nrst)
    svcReq && svcKind == JDEP_SVC_CRC_RANGE && s_reg.prot |=> svcDeny) else $error("range checksum allowed");
  a_prot_services: assert property (@(posedge clk) disable iff (!nrst)
    svcReq && svcKind inside {JDEP_SVC_USER_PAGE, JDEP_SVC_ERASE, JDEP_SVC_IDCODE, JDEP_SVC_HOT_PLUG}
    |=> svcGrant) else $error("permitted service refused");
  a_dbg_units_off: assert property (@(posedge clk) disable iff (!nrst)
    debugUnitsEn != protectedState) else $error("debug units follow wrong state");
  a_pins_on_fall: assert property (@(posedge clk) disable iff (!nrst)
    $rose(pinsEnabled) |-> $past(fall) && $past(s_reg.ent) == JDEP_ENT_ARMED) else $error("pins enabled early");
  a_hold_on_low: assert property (@(posedge clk) disable iff (!nrst)
    relLow |=> coreHoldReset && !pinsEnabled) else $error("hold not set");
  a_hold_clear: assert property (@(posedge clk) disable iff (!nrst)
    svcReq && svcKind == JDEP_SVC_HOLD_CLEAR && !s_reg.prot && rstPinS |=> !coreHoldReset)
    else $error("hold not cleared");
  a_tms_five_reset: assert property (@(posedge clk) disable iff (!nrst)
    tapOn && rise && pinS.tms && tmsHighCnt == 3'h4 |=> s_reg.tap == JDEP_TLR) else $error("no reset after five");
  a_high_stays_off: assert property (@(posedge clk) disable iff (!nrst)
    relHigh ##1 rstPinS [*8] |-> !pinsEnabled && !coreHoldReset) else $error("pins enabled with TCK high");
  a_ir_update: assert property (@(posedge clk) disable iff (!nrst)
    tapOn && rise && s_reg.tap == JDEP_UPD_IR |=> s_reg.ir == $past(s_reg.irShift)) else $error("ir not updated");
  a_idcode_default: assert property (@(posedge clk) disable iff (!nrst)
    s_reg.tap == JDEP_TLR |=> s_reg.ir == `JDEP_IR_IDCODE) else $error("idcode not default");
  a_extest_drive: assert property (@(posedge clk) disable iff (!nrst)
    extest && rstPinS |=> padOeN == '0 && padOut == $past(s_reg.bsUpd[BSC_N-1:0])) else $error("extest not driving");
  a_reset_float: assert property (@(posedge clk) disable iff (!nrst)
    !rstPinS |=> padOeN == '1) else $error("pins driven in reset");
  a_flash_buf_hold: assert property (@(posedge clk) disable iff (!nrst)
    mapIn.req && mapIn.write && mapIn.flashBuf && s_reg.hold |=> mapDeny) else $error("flash buffer written");
  a_map_in_reset: assert property (@(posedge clk) disable iff (!nrst)
    mapIn.req && !rstPinS |=> mapDeny) else $error("access during reset");

  // Boundary latches move only on a rise seen in Update-DR
  a_latch_upd_only: assert property (@(posedge clk) disable iff (!nrst)
    !$stable(s_reg.bsUpd) |-> $past(rise) && $past(s_reg.tap) == JDEP_UPD_DR) else $error("latch moved early");
  // Controller parked in Test-Logic-Reset while the pins are off
  a_tap_parked_off: assert property (@(posedge clk) disable iff (!nrst)
    !tapOn |=> s_reg.tap == JDEP_TLR) else $error("controller not parked");
  // One low TMS period leaves Test-Logic-Reset for Run-Test/Idle
  a_tlr_to_idle: assert property (@(posedge clk) disable iff (!nrst)
    tapOn && rise && s_reg.tap == JDEP_TLR && !pinS.tms |=> s_reg.tap == JDEP_RTI) else $error("no idle entry");
  // Controller moves only on seen TCK rises, or to Test-Logic-Reset while the pins are off
  a_tap_step_rise: assert property (@(posedge clk) disable iff (!nrst)
    s_reg.tap != $past(s_reg.tap) |-> $past(rise) || !$past(tapOn)) else $error("controller stepped alone");
endmodule

// *** rtl/jdep_regs.svh ***
// Constants for the test port with debug entry and protection
// Function
// - While protected, refuse every system-bus access from the memory access port.
// - While protected, ignore hold-clear requests from the system manager port.
// - While protected, checksum only over the whole flash; refuse other ranges.
// - While protected, hot plug, user page read, chip erase and idcode still work.
// - Test pins enable only on a TCK falling edge after reset pin release.
// - TCK low at reset release sets hold-in-reset; core stays in reset.
// - Clearing the hold release status bit drops hold-in-reset.
// - TMS high for five TCK periods reaches Test-Logic-Reset from anywhere.
// - From Test-Logic-Reset, TMS low for one period reaches Run-Test/Idle.
// - TCK high at reset release: pins stay disabled and core is not held.
// - TMS 1,1,0,0 reaches Shift-IR; four instruction bits shift from TDI.
// - Instruction takes effect at Update-IR; 1,1,0 returns to Run-Test/Idle.
// - TMS 1,0,0 reaches Shift-DR; TDI shifts in, capture snapshot shifts out.
// - Parallel outputs change only in Update-DR; idle between scans not needed.
// - Identification instruction is the default after TAP reset.
// - Bypass selects a one-bit path between TDI and TDO.
// - External test drives boundary latches onto pins as soon as it is loaded.
// - Sample/preload captures pins without disturbing them and preloads latches.
// - While the reset pin is low every port pin output floats.
// - Boundary scan runs from TCK edges only; core clock not needed. Here TCK is sampled by the block clock clk, which must run.
// - Memory access port cannot write flash page buffer while core is held.
// - Writing the hold clear control bit releases the core, opening the bus.
// - Only a completed chip erase clears the protected state; here each reset pin release also reloads it from protStrap.
// - Memory access port accesses are impossible while reset pin is low.
`ifndef JDEP_REGS_SVH
`define JDEP_REGS_SVH
`define JDEP_IR_W 4
`define JDEP_DR_W 32
`define JDEP_IR_EXTEST 4'h0
`define JDEP_IR_IDCODE 4'h1
`define JDEP_IR_SAMPLE 4'h2
`define JDEP_IR_BYPASS 4'hf
`define JDEP_IR_CAPTURE 4'h1
`define JDEP_TMS_RESET_CNT 3'h5
`endif

// *** rtl/jdep_pkg.sv ***
// Types for the test port with debug entry and protection
`include "jdep_regs.svh"
package jdep_pkg;
  typedef enum logic [3:0] {
    JDEP_TLR, JDEP_RTI, JDEP_SEL_DR, JDEP_CAP_DR, JDEP_SHIFT_DR, JDEP_EXIT1_DR, JDEP_PAUSE_DR, JDEP_EXIT2_DR,
    JDEP_UPD_DR, JDEP_SEL_IR, JDEP_CAP_IR, JDEP_SHIFT_IR, JDEP_EXIT1_IR, JDEP_PAUSE_IR, JDEP_EXIT2_IR, JDEP_UPD_IR
  } jdep_tap_t;
  typedef enum logic [1:0] {JDEP_ENT_RESET, JDEP_ENT_ARMED, JDEP_ENT_ENABLED, JDEP_ENT_DISABLED} jdep_ent_t;
  typedef enum logic [2:0] {JDEP_SVC_CRC_RANGE, JDEP_SVC_CRC_FLASH, JDEP_SVC_USER_PAGE, JDEP_SVC_ERASE,
    JDEP_SVC_HOLD_CLEAR, JDEP_SVC_IDCODE, JDEP_SVC_HOT_PLUG} jdep_svc_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jdep_pins_t;
  typedef struct packed {
    logic req;
    logic write;
    logic flashBuf;
  } jdep_map_req_t;
  typedef struct packed {
    jdep_tap_t tap;
    jdep_ent_t ent;
    logic tckPrev;
    logic [`JDEP_IR_W-1:0] irShift;
    logic [`JDEP_IR_W-1:0] ir;
    logic [`JDEP_DR_W-1:0] dr;
    logic [`JDEP_DR_W-1:0] bsUpd;
    logic [`JDEP_DR_W-1:0] padOut;
    logic [`JDEP_DR_W-1:0] padOeN;
    logic tdo;
    logic tdoOeN;
    logic hold;
    logic prot;
    logic dbgEn;
    logic mapGrant;
    logic mapDeny;
    logic svcGrant;
    logic svcDeny;
  } jdep_state_t;
endpackage

// *** rtl/jdep_sync.sv ***
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module jdep_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule

// *** dv/jdep_debugger.sv ***
// Debugger model that drives the test clock, mode select and data-in pins
`timescale 1ns/1ps
module jdep_debugger
  import jdep_pkg::*;
(
  output jdep_pins_t pins,
  input wire logic tdo
);
  initial pins = '0;

  // Holds the test clock at a level outside frames
  task automatic tck_level(input logic v);
    pins.tck = v;
  endtask

  // One 160 ns period: set TMS and TDI while low, take TDO just before the rise
  task automatic tck_cycle(input logic tmsV, input logic tdiV, output logic tdoS);
    pins.tms = tmsV;
    pins.tdi = tdiV;
    #80;
    tdoS = tdo;
    pins.tck = 1'b1;
    #80;
    pins.tck = 1'b0;
    pins.tdi = ~tdiV; // Data line no longer holds a valid bit
  endtask

  // Five periods with TMS high, then one low, lands in Run-Test/Idle
  task automatic reset_tap;
    logic d;
    repeat (5) tck_cycle(1'b1, 1'b0, d);
    tck_cycle(1'b0, 1'b0, d);
  endtask

  // Instruction scan: 1,1,0,0 in, four bits LSB first, then 1,1,0 back to idle
  task automatic scan_ir(input logic [3:0] code, output logic [3:0] cap);
    logic d;
    tck_cycle(1'b1, 1'b0, d);
    tck_cycle(1'b1, 1'b0, d);
    tck_cycle(1'b0, 1'b0, d);
    tck_cycle(1'b0, 1'b0, d);
    for (int i = 0; i < 4; i++) begin
      tck_cycle(i == 3, code[i], cap[i]);
    end
    tck_cycle(1'b1, 1'b0, d);
    tck_cycle(1'b0, 1'b0, d);
  endtask

  // Data scan: 1,0,0 in, n bits LSB first, then back to idle through Update-DR
  task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic d;
    dout = '0;
    tck_cycle(1'b1, 1'b0, d);
    tck_cycle(1'b0, 1'b0, d);
    tck_cycle(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      tck_cycle(i == n - 1, din[i], dout[i]);
    end
    tck_cycle(1'b1, 1'b0, d);
    tck_cycle(1'b0, 1'b0, d);
  endtask
endmodule

// *** dv/jdep_top_test.sv ***
// Self-checking bench for the test port with debug entry and protection
`timescale 1ns/1ps
module jdep_top_test;
  import jdep_pkg::*;
  localparam int BSC = 8;
  localparam logic [31:0] ID = 32'h1357_9bdf; // Arbitrary identification value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic extRstN = 1'b0;
  logic protStrap = 1'b0;
  logic eraseDone = 1'b0;
  logic svcReq = 1'b0;
  jdep_svc_t svcKind = JDEP_SVC_IDCODE;
  jdep_map_req_t mapIn = '0;
  jdep_pins_t tapPins;
  logic [BSC-1:0] coreOut = 8'h5a;
  logic [BSC-1:0] coreOeN = 8'h0f;
  logic [BSC-1:0] padIn = 8'ha5;
  logic tdo, tdoOeN, coreHoldReset, pinsEnabled, protectedState, debugUnitsEn;
  logic mapGrant, mapDeny, svcGrant, svcDeny;
  logic [BSC-1:0] padOut, padOeN;
  int mismatches = 0;
  int checked = 0;
  int oeLow = 0;

  // Counts block cycles in which the data-out driver is on
  always @(negedge clk) begin
    if (tdoOeN === 1'b0) begin
      oeLow++;
    end
  end

  always #10 clk = ~clk;

  jdep_debugger deb (.pins(tapPins), .tdo(tdo));

  jdep_top #(.BSC_N(BSC), .ID_CODE(ID)) dut (
    .clk(clk), .nrst(nrst), .tapPins(tapPins), .extRstN(extRstN), .protStrap(protStrap),
    .eraseDone(eraseDone), .mapIn(mapIn), .svcReq(svcReq), .svcKind(svcKind), .coreOut(coreOut),
    .coreOeN(coreOeN), .padIn(padIn), .tdo(tdo), .tdoOeN(tdoOeN), .padOut(padOut), .padOeN(padOeN),
    .coreHoldReset(coreHoldReset), .pinsEnabled(pinsEnabled), .protectedState(protectedState),
    .debugUnitsEn(debugUnitsEn), .mapGrant(mapGrant), .mapDeny(mapDeny), .svcGrant(svcGrant), .svcDeny(svcDeny)
  );

  // Compares one value and reports a mismatch at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One request pulse on the map or service port; exactly one grant or one deny must follow
  task automatic req(input logic svc, input logic wr, input logic fb, input jdep_svc_t kind, input logic expGrant);
    int g;
    int d;
    g = 0;
    d = 0;
    if (svc) begin
      svcKind = kind;
      svcReq = 1'b1;
    end else begin
      mapIn = '{1'b1, wr, fb};
    end
    @(negedge clk);
    svcReq = 1'b0;
    mapIn = '0;
    repeat (2) begin
      g += ((svc ? svcGrant : mapGrant) === 1'b1) ? 1 : 0;
      d += ((svc ? svcDeny : mapDeny) === 1'b1) ? 1 : 0;
      @(negedge clk);
    end
    chk(svc ? "service grants" : "map grants", {31'h0, expGrant}, g);
    chk(svc ? "service denies" : "map denies", {31'h0, !expGrant}, d);
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run time
  initial begin
    #500000;
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [3:0] c;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    req(1'b0, 1'b0, 1'b0, JDEP_SVC_IDCODE, 1'b0);
    extRstN = 1'b1;
    repeat (6) @(negedge clk);
    chk("hold after low-clock release", 32'h1, coreHoldReset);
    chk("pins before clock fall", 32'h0, pinsEnabled);
    req(1'b0, 1'b1, 1'b1, JDEP_SVC_IDCODE, 1'b0);
    deb.tck_level(1'b1);
    repeat (4) @(negedge clk);
    deb.tck_level(1'b0);
    repeat (5) @(negedge clk);
    chk("pins after clock fall", 32'h1, pinsEnabled);
    deb.reset_tap();
    deb.scan_dr(32, 32'h0, r);
    chk("identification scan", ID, r);
    chk("tdo driven while shifting", 32'h1, oeLow > 0);
    chk("tdo released after scan", 32'h1, tdoOeN);
    deb.scan_ir(`JDEP_IR_BYPASS, c);
    chk("instruction capture", 32'h1, c);
    deb.scan_dr(2, 32'h1, r);
    chk("bypass path", 32'h2, r);
    @(negedge clk);
    req(1'b1, 1'b0, 1'b0, JDEP_SVC_HOLD_CLEAR, 1'b1);
    chk("hold after clear", 32'h0, coreHoldReset);
    req(1'b0, 1'b1, 1'b1, JDEP_SVC_IDCODE, 1'b1);
    deb.scan_ir(`JDEP_IR_SAMPLE, c);
    deb.scan_dr(BSC, 32'h3c, r);
    chk("sampled pins", 32'ha5, r);
    chk("pad data in normal use", 32'h5a, padOut);
    chk("pad enables in normal use", 32'h0f, padOeN);
    deb.scan_ir(`JDEP_IR_EXTEST, c);
    repeat (3) @(negedge clk);
    chk("preloaded pad data", 32'h3c, padOut);
    chk("pad enables in external test", 32'h00, padOeN);
    deb.scan_dr(BSC, 32'hc3, r);
    repeat (3) @(negedge clk);
    chk("external test capture", 32'ha5, r);
    chk("updated pad data", 32'hc3, padOut);
    extRstN = 1'b0;
    repeat (4) @(negedge clk);
    chk("pads float in reset", 32'hff, padOeN);
    req(1'b0, 1'b0, 1'b0, JDEP_SVC_IDCODE, 1'b0);
    protStrap = 1'b1;
    deb.tck_level(1'b1);
    extRstN = 1'b1;
    repeat (6) @(negedge clk);
    chk("pins after high-clock release", 32'h0, pinsEnabled);
    chk("hold after high-clock release", 32'h0, coreHoldReset);
    chk("protected state", 32'h1, protectedState);
    chk("debug units while protected", 32'h0, debugUnitsEn);
    for (int k = 0; k < 7; k++) begin
      req(1'b1, 1'b0, 1'b0, jdep_svc_t'(k), !(k == 0 || k == 4));
    end
    req(1'b0, 1'b0, 1'b0, JDEP_SVC_IDCODE, 1'b0);
    eraseDone = 1'b1;
    @(negedge clk);
    eraseDone = 1'b0;
    repeat (2) @(negedge clk);
    chk("protected state after erase", 32'h0, protectedState);
    chk("debug units after erase", 32'h1, debugUnitsEn);
    req(1'b0, 1'b0, 1'b0, JDEP_SVC_IDCODE, 1'b1);
    wrap_up();
  end
endmodule
